// ### hw/etd_divider.sv
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module etd_divider #(
  parameter logic [15:0] BACKUP_HIGH_INIT = 16'h00ff,
  parameter logic [15:0] BACKUP_LOW_INIT = 16'h00ff
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Reference clocks sampled as enables.
  input wire logic oscillator_clock,
  input wire logic bus_clock_ref,
  // AXI4-Lite write address.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [etd_pkg::ETD_ADDR_WIDTH-1:0] s_axi_awaddr,
  // AXI4-Lite write data.
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [etd_pkg::ETD_ADDR_WIDTH-1:0] s_axi_araddr,
  // AXI4-Lite read data.
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Timebase output.
  output logic timebase_tick
);
  import etd_pkg::*;

  // Non-volatile backups: survive reset, hence no reset clause.
  etd_div_pair_type backup;
  etd_div_pair_type next_backup;
  logic backup_init_done = 1'b0;
  logic next_backup_init_done;
  // Volatile divisor.
  etd_div_pair_type divisor;
  etd_div_pair_type next_divisor;
  logic load_pending;
  logic next_load_pending;
  logic [7:0] config_reg;
  logic [7:0] next_config_reg;
  logic refused;
  logic next_refused;
  // Bus channels.
  etd_addr_chan_type aw_hold;
  etd_addr_chan_type next_aw_hold;
  logic w_have;
  logic next_w_have;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic w_lane0;
  logic next_w_lane0;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic awready;
  logic next_awready;
  logic wready;
  logic next_wready;
  logic arready;
  logic next_arready;
  // Divider.
  logic ref_prev;
  logic [ETD_DIV_WIDTH-1:0] count;
  logic [ETD_DIV_WIDTH-1:0] next_count;
  logic tick;
  logic next_tick;
  logic tick_seen;
  logic next_tick_seen;

  logic secure;
  logic write_fire;
  logic [ETD_DIV_WIDTH-1:0] div_value;
  logic ref_sel;
  logic ref_edge;
  logic div_writable;
  logic backup_cmd;

  assign secure = ~divisor.high[ETD_SECD_BIT];
  assign div_value = {divisor.high[ETD_HIGH_DIV_BITS-1:0], divisor.low};
  assign write_fire = aw_hold.valid && w_have && !bvalid;
  assign ref_sel = config_reg[ETD_CFG_REFSEL_BIT] ? bus_clock_ref : oscillator_clock;
  assign ref_edge = ref_sel && !ref_prev;
  assign div_writable = !secure && !config_reg[ETD_CFG_LATCH_BIT];
  assign backup_cmd = write_fire && w_lane0 && (aw_hold.addr == ETD_ADDR_BACKUP_CMD);

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_have = w_have;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_divisor = divisor;
    next_load_pending = 1'b0;
    next_config_reg = config_reg;
    next_refused = refused;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_tick_seen = tick_seen | tick;
    // A zero backup bit locks again each reset.
    if (load_pending) begin
      next_divisor = backup;
    end
    if (s_axi_awvalid && !aw_hold.valid) begin
      next_aw_hold.valid = 1'b1;
      next_aw_hold.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have) begin
      next_w_have = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (write_fire) begin
      next_aw_hold.valid = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = ETD_RESP_OKAY;
      if (w_lane0) begin
        case (aw_hold.addr)
          // Write gated by latch and security.
          ETD_ADDR_DIV_HIGH: begin
            if (div_writable) begin
              next_divisor.high = w_data[7:0];
            end
          end
          ETD_ADDR_DIV_LOW: begin
            if (div_writable) begin
              next_divisor.low = w_data[7:0];
            end
          end
          ETD_ADDR_CONFIG: begin
            next_config_reg = w_data[7:0];
          end
          ETD_ADDR_BACKUP_CMD: begin
            if (secure) begin
              next_refused = 1'b1;
            end
          end
          ETD_ADDR_STATUS: begin
            if (w_data[ETD_ST_REFUSED_BIT]) begin
              next_refused = 1'b0;
            end
            if (w_data[ETD_ST_TICK_BIT]) begin
              next_tick_seen = tick;
            end
          end
          ETD_ADDR_BACKUP_HIGH, ETD_ADDR_BACKUP_LOW: begin
            next_bresp = ETD_RESP_OKAY;
          end
          default: begin
            next_bresp = ETD_RESP_SLVERR;
          end
        endcase
      end
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = ETD_RESP_OKAY;
      next_rdata = ETD_ZERO_WORD;
      case (s_axi_araddr)
        ETD_ADDR_DIV_HIGH: next_rdata[7:0] = divisor.high;
        ETD_ADDR_DIV_LOW: next_rdata[7:0] = divisor.low;
        ETD_ADDR_BACKUP_HIGH: next_rdata[7:0] = backup.high;
        ETD_ADDR_BACKUP_LOW: next_rdata[7:0] = backup.low;
        ETD_ADDR_CONFIG: next_rdata[7:0] = config_reg;
        ETD_ADDR_BACKUP_CMD: next_rdata = ETD_ZERO_WORD;
        ETD_ADDR_STATUS: begin
          next_rdata[ETD_ST_SECURE_BIT] = secure;
          next_rdata[ETD_ST_REFUSED_BIT] = refused;
          next_rdata[ETD_ST_TICK_BIT] = tick_seen;
        end
        default: next_rresp = ETD_RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_hold.valid;
    next_wready = !next_w_have;
    next_arready = !next_rvalid;
  end

  // Backup writes do not touch the divisor.
  // Program clears bits, erase sets the byte.
  always_comb begin
    next_backup = backup;
    next_backup_init_done = 1'b1;
    if (!backup_init_done) begin
      next_backup.high = BACKUP_HIGH_INIT[7:0];
      next_backup.low = BACKUP_LOW_INIT[7:0];
    end else if (backup_cmd && !secure) begin
      if (w_data[ETD_CMD_ERASE_BIT]) begin
        if (w_data[ETD_CMD_HIGH_BIT]) begin
          next_backup.high = ETD_ERASED_BYTE;
        end else begin
          next_backup.low = ETD_ERASED_BYTE;
        end
      end else if (w_data[ETD_CMD_PROGRAM_BIT]) begin
        if (w_data[ETD_CMD_HIGH_BIT]) begin
          next_backup.high = backup.high & w_data[15:8];
        end else begin
          next_backup.low = backup.low & w_data[15:8];
        end
      end
    end
  end

  // Divide the reference to the timebase.
  // Count to the divisor, tick, restart.
  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (ref_edge) begin
      if (div_value != '0 && count >= div_value - 1'b1) begin
        next_count = '0;
        next_tick = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  // Backup storage keeps its value through reset.
  always_ff @(posedge aclk) begin
    backup <= next_backup;
    backup_init_done <= next_backup_init_done;
  end

  // Register state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divisor <= '0;
      load_pending <= 1'b1;
      config_reg <= 8'h00;
      refused <= 1'b0;
      tick_seen <= 1'b0;
    end else begin
      divisor <= next_divisor;
      load_pending <= next_load_pending;
      config_reg <= next_config_reg;
      refused <= next_refused;
      tick_seen <= next_tick_seen;
    end
  end

  // Bus channel state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= '0;
      w_have <= 1'b0;
      w_data <= ETD_ZERO_WORD;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= ETD_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= ETD_ZERO_WORD;
      rresp <= ETD_RESP_OKAY;
      awready <= 1'b1;
      wready <= 1'b1;
      arready <= 1'b1;
    end else begin
      aw_hold <= next_aw_hold;
      w_have <= next_w_have;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
    end
  end

  // Divider state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev <= 1'b0;
      count <= '0;
      tick <= 1'b0;
    end else begin
      ref_prev <= ref_sel;
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign s_axi_awready = awready;
  assign s_axi_wready = wready;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = arready;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign timebase_tick = tick;

endmodule

// ### hw/etd_pkg.sv
package etd_pkg;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [7:0] ETD_ADDR_DIV_HIGH = 8'h00;
  localparam logic [7:0] ETD_ADDR_DIV_LOW = 8'h04;
  localparam logic [7:0] ETD_ADDR_BACKUP_HIGH = 8'h08;
  localparam logic [7:0] ETD_ADDR_BACKUP_LOW = 8'h0c;
  localparam logic [7:0] ETD_ADDR_CONFIG = 8'h10;
  localparam logic [7:0] ETD_ADDR_BACKUP_CMD = 8'h14;
  localparam logic [7:0] ETD_ADDR_STATUS = 8'h18;
  localparam int ETD_ADDR_WIDTH = 8;

  // Field layout.
  localparam int ETD_DIV_WIDTH = 11;
  localparam int ETD_HIGH_DIV_BITS = 3;
  localparam int ETD_SECD_BIT = 7;
  localparam int ETD_CFG_REFSEL_BIT = 0;
  localparam int ETD_CFG_LATCH_BIT = 1;
  localparam int ETD_CMD_PROGRAM_BIT = 0;
  localparam int ETD_CMD_ERASE_BIT = 1;
  localparam int ETD_CMD_HIGH_BIT = 2;
  localparam int ETD_ST_SECURE_BIT = 0;
  localparam int ETD_ST_REFUSED_BIT = 1;
  localparam int ETD_ST_TICK_BIT = 2;

  // Reset and erased values.
  localparam logic [7:0] ETD_ERASED_BYTE = 8'hff;
  localparam logic [1:0] ETD_RESP_OKAY = 2'b00;
  localparam logic [1:0] ETD_RESP_SLVERR = 2'b10;
  localparam logic [31:0] ETD_ZERO_WORD = 32'h0000_0000;

  // Timebase period in nanoseconds.
  localparam int ETD_TIMEBASE_NS = 35000;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } etd_div_pair_type;

  typedef struct packed {
    logic valid;
    logic [ETD_ADDR_WIDTH-1:0] addr;
  } etd_addr_chan_type;

endpackage

// ### testbench/etd_divider_props.sv
`timescale 1ns/1ps
module etd_divider_props (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [etd_pkg::ETD_ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Timebase.
  input wire logic timebase_tick
);
  import etd_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  rd_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ETD_ADDR_STATUS
    |=> s_axi_rresp == ETD_RESP_SLVERR) else $error("unmapped read not refused");
  rd_ok_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= ETD_ADDR_STATUS
    && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == ETD_RESP_OKAY) else $error("mapped read refused");
  b_after_both_a: assert property ($rose(s_axi_bvalid)
    |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write answered before address and data held");
  tick_pulse_a:
    assert property (timebase_tick |=> !timebase_tick) else $error("tick longer than one cycle");
  reset_quiet_a:
    assert property (!$past(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !timebase_tick)
    else $error("outputs active after reset");
  tick_c: cover property (timebase_tick);
  slverr_c: cover property (s_axi_rvalid && s_axi_rresp == ETD_RESP_SLVERR);
  wresp_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ### testbench/etd_divider_tb.sv
`timescale 1ns/1ps
module etd_divider_tb;
  import etd_pkg::*;
  logic aclk, aresetn, oscillator_clock, bus_clock_ref, timebase_tick;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q, ref_div;
  int n_fail = 0, compares = 0, cyc = 0;
  localparam int REF_HZ = 32'h0003_d090;
  localparam int DIV_SLOW = (REF_HZ * 32'h0000_0023 + 32'h0007_a120) / 32'h000f_4240;
  etd_divider dut (.aclk, .aresetn, .oscillator_clock, .bus_clock_ref, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .timebase_tick);
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  // Bus reference toggles every cycle, oscillator reference has a 4 cycle period.
  always @(posedge aclk) begin
    bus_clock_ref <= ~bus_clock_ref;
    ref_div <= ref_div + 2'h1;
    oscillator_clock <= ref_div[1];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp_q = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rh(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_q & m, e);
  endtask
  // Measures the clock cycles between two consecutive ticks.
  task automatic gap(input logic [31:0] e);
    logic [31:0] n;
    n = 32'h0000_0000;
    @(posedge aclk iff timebase_tick);
    do begin
      @(posedge aclk);
      n++;
    end while (!timebase_tick);
    chk(n, e);
  endtask
  task automatic t_reset();
    rh(ETD_ADDR_DIV_HIGH, 32'h0000_0087, 32'h0000_0087);
    rh(ETD_ADDR_DIV_LOW, 32'hffff_ffff, 32'h0000_00ff);
    rh(ETD_ADDR_BACKUP_LOW, 32'h0000_00ff, 32'h0000_00ff);
    rd(8'h1c);
    chk(32'(resp_q), 32'(ETD_RESP_SLVERR));
    wr(8'h1c, 32'h0000_0000);
    chk(32'(resp_q), 32'(ETD_RESP_SLVERR));
    $display("test reset done");
  endtask
  task automatic t_tick();
    wr(ETD_ADDR_DIV_LOW, 32'h0000_0003);
    wr(ETD_ADDR_DIV_HIGH, 32'h0000_0080);
    rh(ETD_ADDR_DIV_LOW, 32'h0000_00ff, 32'h0000_0003);
    wr(ETD_ADDR_CONFIG, 32'h0000_0001);
    gap(32'h0000_0006);
    rh(ETD_ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
    wr(ETD_ADDR_CONFIG, 32'h0000_0000);
    wr(ETD_ADDR_DIV_LOW, 32'h0000_0003);
    gap(32'h0000_000c);
    wr(ETD_ADDR_CONFIG, 32'h0000_0002);
    wr(ETD_ADDR_DIV_LOW, 32'(DIV_SLOW));
    rh(ETD_ADDR_DIV_LOW, 32'h0000_00ff, 32'h0000_0003);
    wr(ETD_ADDR_CONFIG, 32'h0000_0000);
    $display("test tick done");
  endtask
  task automatic t_backup();
    wr(ETD_ADDR_BACKUP_CMD, 32'h0000_0501);
    rh(ETD_ADDR_BACKUP_LOW, 32'h0000_00ff, 32'h0000_0005);
    rh(ETD_ADDR_DIV_LOW, 32'h0000_00ff, 32'h0000_0003);
    wr(ETD_ADDR_BACKUP_CMD, 32'h0000_0002);
    rh(ETD_ADDR_BACKUP_LOW, 32'h0000_00ff, 32'h0000_00ff);
    wr(ETD_ADDR_BACKUP_CMD, 32'h0000_0501);
    wr(ETD_ADDR_BACKUP_CMD, 32'h0000_0205);
    rh(ETD_ADDR_DIV_HIGH, 32'h0000_0087, 32'h0000_0080);
    do_reset();
    rh(ETD_ADDR_DIV_HIGH, 32'h0000_0087, 32'h0000_0002);
    rh(ETD_ADDR_DIV_LOW, 32'h0000_00ff, 32'h0000_0005);
    rh(ETD_ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    wr(ETD_ADDR_DIV_HIGH, 32'h0000_0087);
    rh(ETD_ADDR_DIV_HIGH, 32'h0000_0087, 32'h0000_0002);
    wr(ETD_ADDR_BACKUP_CMD, 32'h0000_0006);
    rh(ETD_ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
    wr(ETD_ADDR_STATUS, 32'h0000_0002);
    rh(ETD_ADDR_STATUS, 32'h0000_0002, 32'h0000_0000);
    rh(ETD_ADDR_BACKUP_HIGH, 32'h0000_00ff, 32'h0000_0002);
    do_reset();
    rh(ETD_ADDR_DIV_HIGH, 32'h0000_0080, 32'h0000_0000);
    $display("test backup done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {aresetn, oscillator_clock, bus_clock_ref, s_axi_awvalid, s_axi_wvalid} = 5'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, ref_div} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hf;
    do_reset();
    t_reset();
    t_tick();
    t_backup();
    report_and_stop();
  end
endmodule
bind etd_divider etd_divider_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .timebase_tick);
